// *** core/io_function_mux.sv ***
// Per-pin function multiplexer between peripherals and package pads.
`timescale 1ns/1ps
module io_function_mux
    import io_mux_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic [NPIN-1:0][1:0] pin_mode_field_in,
    input wire logic [NPIN-1:0][AF_W-1:0] alt_function_index_in,
    input wire logic [NPIN-1:0] gpio_out_in,
    input wire logic low_speed_crystal_enable_in,
    input wire logic amp_cap_select_in,
    input wire logic radio_tx_busy_in,
    input wire logic radio_rx_busy_in,
    input wire logic [NSIG-1:0] periph_drive_in,
    input wire logic [NSIG-1:0] periph_drive_en_in,
    input wire logic [NPIN-1:0] pad_in,
    output logic [NPIN-1:0] pad_out,
    output logic [NPIN-1:0] pad_oe_n_out,
    output logic [NPIN-1:0] gpio_in_out,
    output logic [NSIG-1:0] periph_sense_out,
    output logic [NPIN-1:0] analog_switch_out,
    output logic [1:0] converter_channel0_input_out,
    output logic [1:0] amplifier_cap_pin_out,
    output logic [1:0] low_speed_crystal_out
);

    // ------------------------------------------------------------
    // Pad synchroniser
    // ------------------------------------------------------------
    pad_sync_if #(.W(NPIN)) pads ();

    assign pads.raw = pad_in;

    pad_sync #(
        .W(NPIN)
    ) u_pad_sync (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .port(pads.sync)
    );

    // ------------------------------------------------------------
    // Routing
    // ------------------------------------------------------------
    mux_state_t st_r;
    mux_state_t st_nxt;

    // Whole routing decided per pin; descending loop so the lowest
    // pin wins when two pins select the same peripheral input
    always_comb begin
        logic [NSIG-1:0] drv;
        logic [NSIG-1:0] drv_en;
        logic [SIG_W-1:0] id;
        logic [4:0] pin;
        pin_mode_t mode;
        logic xtal;
        drv = periph_drive_in;
        drv_en = periph_drive_en_in;
        id = SIG_NONE;
        pin = '0;
        mode = MODE_INPUT;
        xtal = 1'b0;
        st_nxt = MUX_RESET;
        drv[SIG_RADIO_TX_ACT] = radio_tx_busy_in;
        drv[SIG_RADIO_RX_ACT] = radio_rx_busy_in;
        drv_en[SIG_RADIO_TX_ACT] = 1'b1;
        drv_en[SIG_RADIO_RX_ACT] = 1'b1;
        for (int p = NPIN - 1; p >= 0; p--) begin
            pin = 5'(p);
            mode = pin_mode_t'(pin_mode_field_in[p]);
            id = af_lookup(pin, alt_function_index_in[p]);
            xtal = low_speed_crystal_enable_in &&
                (p == PIN_PB12 || p == PIN_PB13);
            if (xtal) begin
                // oscillator owns the pad, drivers released
                st_nxt.pad_oe_n[p] = 1'b1;
                st_nxt.xtal_sw[p - PIN_PB12] = 1'b1;
            end else begin
                case (mode)
                    MODE_INPUT: begin
                        st_nxt.gpio_in[p] = pads.clean[p];
                    end
                    MODE_OUTPUT: begin
                        st_nxt.pad_out[p] = gpio_out_in[p];
                        st_nxt.pad_oe_n[p] = 1'b0;
                        st_nxt.gpio_in[p] = pads.clean[p];
                    end
                    MODE_ALT: begin
                        st_nxt.gpio_in[p] = pads.clean[p];
                        if (id != SIG_NONE) begin
                            st_nxt.sense[id] = pads.clean[p];
                            st_nxt.pad_oe_n[p] = !drv_en[id];
                            st_nxt.pad_out[p] = drv_en[id] ?
                                drv[id] : PRESET_HIGH[id];
                        end
                    end
                    MODE_ANALOG: begin
                        // analog path only on capable pins
                        if (!ANALOG_PINS[p]) begin
                            st_nxt.gpio_in[p] = pads.clean[p];
                        end else if (p == PIN_PB2 || p == PIN_PB3) begin
                            st_nxt.cap_sw[p - PIN_PB2] = amp_cap_select_in;
                            st_nxt.ch0_sw[p - PIN_PB2] = !amp_cap_select_in;
                        end else begin
                            st_nxt.analog_sw[p] = 1'b1;
                        end
                    end
                    default: begin
                        st_nxt.pad_oe_n[p] = 1'b1;
                    end
                endcase
            end
        end
    end

    // State register; every output is a flop of it
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r <= MUX_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pad_out = st_r.pad_out;
    assign pad_oe_n_out = st_r.pad_oe_n;
    assign gpio_in_out = st_r.gpio_in;
    // unselected inputs keep the idle level
    assign periph_sense_out = st_r.sense;
    assign analog_switch_out = st_r.analog_sw;
    assign converter_channel0_input_out = st_r.ch0_sw;
    assign amplifier_cap_pin_out = st_r.cap_sw;
    assign low_speed_crystal_out = st_r.xtal_sw;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);

    function automatic logic alt_at(input int p, input int idx);
        return pin_mode_field_in[p] == MODE_ALT &&
            alt_function_index_in[p] == AF_W'(idx);
    endfunction

    logic swclk_selected;
    assign swclk_selected = alt_at(PIN_PA3, 0) || alt_at(PIN_PA3, 5) ||
        alt_at(PIN_PA3, 7) || alt_at(PIN_PA13, 1);

    sequence s_xtal_held;
        low_speed_crystal_enable_in ##1 low_speed_crystal_enable_in;
    endsequence

    property p_input_released;
        pin_mode_field_in[PIN_PA4] == MODE_INPUT |=> pad_oe_n_out[PIN_PA4];
    endproperty
    a_input_released: assert property (p_input_released)
        else $error("input pin is driven");

    property p_rtc_index2;
        alt_at(PIN_PA9, 2) |=> pad_out[PIN_PA9] == $past(
            periph_drive_en_in[SIG_RTC_OUT] ?
            periph_drive_in[SIG_RTC_OUT] : 1'b0);
    endproperty
    a_rtc_index2: assert property (p_rtc_index2)
        else $error("index 2 on PA9 does not carry the rtc output");

    property p_unselected_idle;
        !swclk_selected |=>
            periph_sense_out[SIG_SWCLK] == SENSE_IDLE[SIG_SWCLK];
    endproperty
    a_unselected_idle: assert property (p_unselected_idle)
        else $error("detached debug clock input not idle");

    property p_swd_alias;
        (alt_at(PIN_PA2, 5) || alt_at(PIN_PA2, 7)) |=>
            pad_oe_n_out[PIN_PA2] == !$past(periph_drive_en_in[SIG_SWDIO]);
    endproperty
    a_swd_alias: assert property (p_swd_alias)
        else $error("debug data not on PA2 at index 5 or 7");

    property p_usart_tx_pb15;
        alt_at(PIN_PB15, 7) && periph_drive_en_in[SIG_USART_TX] |=>
            !pad_oe_n_out[PIN_PB15] &&
            pad_out[PIN_PB15] == $past(periph_drive_in[SIG_USART_TX]);
    endproperty
    a_usart_tx_pb15: assert property (p_usart_tx_pb15)
        else $error("USART transmit not on PB15 at index 7");

    // Transmit activity checked on each of its two pads alone, since
    // the other pad may be a general output at the same time
    property p_tx_activity;
        alt_at(PIN_PA10, 2) |=> !pad_oe_n_out[PIN_PA10] &&
            pad_out[PIN_PA10] == $past(radio_tx_busy_in);
    endproperty
    a_tx_activity: assert property (p_tx_activity)
        else $error("transmit activity not on PA10");

    property p_tx_activity_pb15;
        alt_at(PIN_PB15, 1) |=> !pad_oe_n_out[PIN_PB15] &&
            pad_out[PIN_PB15] == $past(radio_tx_busy_in);
    endproperty
    a_tx_activity_pb15: assert property (p_tx_activity_pb15)
        else $error("transmit activity not on PB15");

    property p_rx_activity;
        alt_at(PIN_PA11, 2) |=> !pad_oe_n_out[PIN_PA11] &&
            pad_out[PIN_PA11] == $past(radio_rx_busy_in);
    endproperty
    a_rx_activity: assert property (p_rx_activity)
        else $error("receive activity not on PA11");

    property p_i2c_preset;
        alt_at(PIN_PA0, 0) && !periph_drive_en_in[SIG_I2C1_SCL] |=>
            pad_out[PIN_PA0] && pad_oe_n_out[PIN_PA0];
    endproperty
    a_i2c_preset: assert property (p_i2c_preset)
        else $error("I2C clock pin not preset high");

    property p_uart_rx_preset;
        alt_at(PIN_PB0, 0) && !periph_drive_en_in[SIG_USART_RX] |=>
            !pad_out[PIN_PB0];
    endproperty
    a_uart_rx_preset: assert property (p_uart_rx_preset)
        else $error("UART receive pin not preset low");

    property p_analog_only;
        1'b1 |=> analog_switch_out[PIN_PA12] ==
            ($past(pin_mode_field_in[PIN_PA12]) == MODE_ANALOG);
    endproperty
    a_analog_only: assert property (p_analog_only)
        else $error("converter switch disagrees with analog mode");

    property p_cap_select;
        pin_mode_field_in[PIN_PB3] == MODE_ANALOG |=>
            amplifier_cap_pin_out[1] == $past(amp_cap_select_in) &&
            converter_channel0_input_out[1] == !$past(amp_cap_select_in);
    endproperty
    a_cap_select: assert property (p_cap_select)
        else $error("PB3 analog selection wrong");

    property p_xtal_takeover;
        s_xtal_held |-> pad_oe_n_out[PIN_PB12] &&
            pad_oe_n_out[PIN_PB13] && (&low_speed_crystal_out);
    endproperty
    a_xtal_takeover: assert property (p_xtal_takeover)
        else $error("crystal pins not taken over");

    property p_pa8_mosi;
        alt_at(PIN_PA8, 1) && periph_drive_en_in[SIG_SPI_FIRST_CTRL_OUT_LINE]
            |=> pad_out[PIN_PA8] ==
            $past(periph_drive_in[SIG_SPI_FIRST_CTRL_OUT_LINE]);
    endproperty
    a_pa8_mosi: assert property (p_pa8_mosi)
        else $error("SPI1 data out not on PA8 at index 1");

    property p_rx_activity_pa8;
        alt_at(PIN_PA8, 2) |=> !pad_oe_n_out[PIN_PA8] &&
            pad_out[PIN_PA8] == $past(radio_rx_busy_in);
    endproperty
    a_rx_activity_pa8: assert property (p_rx_activity_pa8)
        else $error("receive activity not on PA8");

    property p_uart_tx_preset;
        alt_at(PIN_PA9, 0) && !periph_drive_en_in[SIG_USART_TX] |=>
            pad_out[PIN_PA9] && pad_oe_n_out[PIN_PA9];
    endproperty
    a_uart_tx_preset: assert property (p_uart_tx_preset)
        else $error("UART transmit pin not preset high");

    property p_usart_tx_idle_pb15;
        alt_at(PIN_PB15, 7) && !periph_drive_en_in[SIG_USART_TX] |=>
            pad_out[PIN_PB15] && pad_oe_n_out[PIN_PB15];
    endproperty
    a_usart_tx_idle_pb15: assert property (p_usart_tx_idle_pb15)
        else $error("idle USART transmit on PB15 not high");

    property p_output_mode;
        pin_mode_field_in[PIN_PA4] == MODE_OUTPUT |=>
            !pad_oe_n_out[PIN_PA4] &&
            pad_out[PIN_PA4] == $past(gpio_out_in[PIN_PA4]);
    endproperty
    a_output_mode: assert property (p_output_mode)
        else $error("output pin does not drive its data");

    // Oscillator pads give nothing to the general input path
    property p_xtal_no_sense;
        low_speed_crystal_enable_in |=>
            !gpio_in_out[PIN_PB12] && !gpio_in_out[PIN_PB13];
    endproperty
    a_xtal_no_sense: assert property (p_xtal_no_sense)
        else $error("crystal pins still feed the input path");

    property p_cap_select_pb2;
        1'b1 |=> amplifier_cap_pin_out[0] ==
            ($past(pin_mode_field_in[PIN_PB2]) == MODE_ANALOG &&
            $past(amp_cap_select_in));
    endproperty
    a_cap_select_pb2: assert property (p_cap_select_pb2)
        else $error("PB2 capacitor switch wrong");

endmodule

// *** include/io_mux_pkg.sv ***
// Constants, signal map and state types of the pin function multiplexer.
package io_mux_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NPIN = 32;
    localparam int NSIG = 50;
    localparam int SIG_W = 6;
    localparam int AF_W = 3;
    localparam int PB_BASE = 16;

    typedef enum logic [1:0] {
        MODE_INPUT,
        MODE_OUTPUT,
        MODE_ALT,
        MODE_ANALOG
    } pin_mode_t;

    // ------------------------------------------------------------
    // Pin positions
    // ------------------------------------------------------------
    localparam int PIN_PA0 = 0;
    localparam int PIN_PA2 = 2;
    localparam int PIN_PA3 = 3;
    localparam int PIN_PA4 = 4;
    localparam int PIN_PA8 = 8;
    localparam int PIN_PA9 = 9;
    localparam int PIN_PA10 = 10;
    localparam int PIN_PA11 = 11;
    localparam int PIN_PA12 = 12;
    localparam int PIN_PA13 = 13;
    localparam int PIN_PB0 = PB_BASE;
    localparam int PIN_PB2 = PB_BASE + 2;
    localparam int PIN_PB3 = PB_BASE + 3;
    localparam int PIN_PB12 = PB_BASE + 12;
    localparam int PIN_PB13 = PB_BASE + 13;
    localparam int PIN_PB15 = PB_BASE + 15;

    // Pins with a converter or microphone path
    localparam logic [NPIN-1:0] ANALOG_PINS = 32'h003f_f000;

    // ------------------------------------------------------------
    // Peripheral signal numbers, zero means no function
    // ------------------------------------------------------------
    localparam logic [SIG_W-1:0] SIG_NONE = 6'h00;
    localparam int SIG_I2C1_SCL = 1;
    localparam int SIG_USART_RX = 7;
    localparam int SIG_USART_TX = 8;
    localparam int SIG_SPI_FIRST_CTRL_OUT_LINE = 19;
    localparam int SIG_SWDIO = 30;
    localparam int SIG_SWCLK = 31;
    localparam int SIG_RADIO_TX_ACT = 32;
    localparam int SIG_RADIO_RX_ACT = 33;
    localparam int SIG_RTC_OUT = 34;

    // Output level shown before the peripheral drives: I2C and UART tx
    localparam logic [NSIG-1:0] PRESET_HIGH = 50'h0_0000_0000_217e;
    // Idle level for unselected inputs: I2C, UART lines, handshakes
    localparam logic [NSIG-1:0] SENSE_IDLE = 50'h0_0000_0000_ffff;

    // Map per pin, one byte per index, index 7 in the top byte
    localparam logic [63:0] AF_MAP [NPIN] = '{
        64'h0000_002c_0018_0a01, 64'h0000_002d_0008_1602,
        64'h1e00_1e00_1d27_091e, 64'h1f00_1f00_1928_0b1f,
        64'h0000_002a_0d00_1523, 64'h0000_002b_0c00_1424,
        64'h0000_002a_1500_170e, 64'h0000_002b_1400_160f,
        64'h0000_002c_1b21_1307, 64'h0000_002d_1a22_1008,
        64'h0000_0000_1d20_1223, 64'h0000_0000_1c21_1124,
        64'h0000_002a_1711_1e03, 64'h0000_0029_1610_1f04,
        64'h0000_0027_0012_0005, 64'h0000_0028_0013_0006,
        64'h0000_0000_2f00_0f07, 64'h0000_0000_2900_2511,
        64'h0000_0000_2c00_260b, 64'h0000_0000_2d00_0d0a,
        64'h0000_0000_2600_160d, 64'h0000_0000_2500_170c,
        64'h0000_002a_0d00_1504, 64'h0000_002b_0c00_1405,
        64'h0000_002e_2d00_0c09, 64'h0000_002f_2e18_0e08,
        64'h0000_0030_2b02_1411, 64'h0000_0031_2a01_1510,
        64'h0000_002c_2726_2310, 64'h0000_002d_2825_0412,
        64'h0700_0000_3029_0513, 64'h0800_0000_3100_2000
    };

    // ------------------------------------------------------------
    // Registered state of the multiplexer
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NPIN-1:0] pad_out;
        logic [NPIN-1:0] pad_oe_n;
        logic [NPIN-1:0] gpio_in;
        logic [NSIG-1:0] sense;
        logic [NPIN-1:0] analog_sw;
        logic [1:0] ch0_sw;
        logic [1:0] cap_sw;
        logic [1:0] xtal_sw;
    } mux_state_t;

    localparam mux_state_t MUX_RESET = '{
        pad_out: '0,
        pad_oe_n: '1,
        gpio_in: '0,
        sense: SENSE_IDLE,
        analog_sw: '0,
        ch0_sw: '0,
        cap_sw: '0,
        xtal_sw: '0
    };

    // Signal number routed by a pin at an alternate index
    function automatic logic [SIG_W-1:0] af_lookup(
        input logic [4:0] pin,
        input logic [AF_W-1:0] idx
    );
        logic [63:0] row;
        row = AF_MAP[pin];
        return row[{idx, 3'h0} +: SIG_W];
    endfunction

endpackage

// *** include/pad_sync_if.sv ***
// Bundle between the mux and its pad input synchroniser.
`timescale 1ns/1ps
interface pad_sync_if #(
    parameter int W = 32
);
    logic [W-1:0] raw;
    logic [W-1:0] clean;

    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// *** core/pad_sync.sv ***
// Three-stage pad input synchroniser with agreement filter.
`timescale 1ns/1ps
module pad_sync #(
    parameter int W = 32
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    pad_sync_if.sync port
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] clean;
    } sync_state_t;

    sync_state_t st_r;
    sync_state_t st_nxt;

    // Stage one feeds stage two only; a new level counts once the
    // last two stages agree, so a single metastable beat is dropped
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = port.raw;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < W; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.clean[i] = st_r.s3[i];
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign port.clean = st_r.clean;

endmodule

// *** bench/pad_world.sv ***
// Outside world of the package pads: resolves each pad wire level.
`timescale 1ns/1ps
module pad_world
    import io_mux_pkg::*;
(
    input wire logic [NPIN-1:0] pad_out_in,
    input wire logic [NPIN-1:0] pad_oe_n_in,
    input wire logic [NPIN-1:0] ext_level_in,
    output logic [NPIN-1:0] pad_level_out
);
    // ------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------
    // Driven pad wins; a released pad shows the outside device's level,
    // which the bench reshuffles, so a stale value never looks right
    assign pad_level_out = (~pad_oe_n_in & pad_out_in) |
                           (pad_oe_n_in & ext_level_in);
endmodule

// *** bench/io_function_mux_tb.sv ***
// Self-checking bench of the pin function multiplexer.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("MISMATCH %s exp=%h got=%h", nm, e, g); \
    end \
end
module io_function_mux_tb
    import io_mux_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus, outputs and model state
    // ------------------------------------------------------------
    logic clk_sys_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [NPIN-1:0][1:0] pin_mode = '0;
    logic [NPIN-1:0][AF_W-1:0] alt_idx = '0;
    logic [NPIN-1:0] gpo = '0, ext = '0, pad_lvl;
    logic xen = 1'b0, amp = 1'b0, txb = 1'b0, rxb = 1'b0;
    logic [NSIG-1:0] pdrv = '0, pden = '0, sen, e_sen;
    logic [NPIN-1:0] p_out, p_oe_n, g_in, asw;
    logic [NPIN-1:0] e_out, e_oe, e_gin, e_asw;
    logic [1:0] ch0, cap, xtal, e_ch0, e_cap;
    int n_errors = 0, n_compared = 0;
    int seed = 32'h72695a72;
    // Routed pins: pin, index, documented signal number
    localparam int D_N = 14;
    localparam int D_PIN [D_N] = '{2, 2, 2, 3, 3, 30, 31, 10, 31, 8, 11,
                                   8, 0, 9};
    localparam int D_IDX [D_N] = '{0, 5, 7, 5, 7, 7, 7, 2, 1, 2, 2, 1,
                                   0, 0};
    localparam int D_SIG [D_N] = '{30, 30, 30, 31, 31, 7, 8, 32, 32, 33,
                                   33, 19, 1, 8};

    // 50 MHz system clock
    always #10 clk_sys_in = ~clk_sys_in;

    io_function_mux u_io_function_mux (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .pin_mode_field_in(pin_mode), .alt_function_index_in(alt_idx),
        .gpio_out_in(gpo), .low_speed_crystal_enable_in(xen),
        .amp_cap_select_in(amp), .radio_tx_busy_in(txb),
        .radio_rx_busy_in(rxb), .periph_drive_in(pdrv),
        .periph_drive_en_in(pden), .pad_in(pad_lvl), .pad_out(p_out),
        .pad_oe_n_out(p_oe_n), .gpio_in_out(g_in),
        .periph_sense_out(sen), .analog_switch_out(asw),
        .converter_channel0_input_out(ch0),
        .amplifier_cap_pin_out(cap), .low_speed_crystal_out(xtal)
    );
    pad_world u_pad_world (
        .pad_out_in(p_out), .pad_oe_n_in(p_oe_n), .ext_level_in(ext),
        .pad_level_out(pad_lvl)
    );

    // ------------------------------------------------------------
    // Behavioural model
    // ------------------------------------------------------------
    // Idle output level: I2C lines and the two transmit lines sit high
    function automatic logic preset_of(input int s);
        return (s >= 1 && s <= 6) || s == SIG_USART_TX || s == 13;
    endfunction

    // Walk pins downwards so the lowest pin claims a shared input
    function automatic void predict();
        logic [63:0] row;
        int s;
        logic xp, an, lv;
        e_out = '0;
        e_oe = '1;
        e_gin = '0;
        e_asw = '0;
        e_sen = SENSE_IDLE;
        for (int p = NPIN - 1; p >= 0; p--) begin
            row = AF_MAP[p];
            s = row[alt_idx[p] * 8 +: SIG_W];
            xp = xen && (p == PIN_PB12 || p == PIN_PB13);
            an = pin_mode[p] == 2'd3 && p >= PIN_PA12 && p <= PB_BASE + 5;
            if (!xp && pin_mode[p] == 2'd1) begin
                e_oe[p] = 1'b0;
                e_out[p] = gpo[p];
            end
            if (!xp && pin_mode[p] == 2'd2 && s != 0) begin
                if (s == SIG_RADIO_TX_ACT || s == SIG_RADIO_RX_ACT) begin
                    e_oe[p] = 1'b0;
                    e_out[p] = (s == SIG_RADIO_TX_ACT) ? txb : rxb;
                end else if (pden[s]) begin
                    e_oe[p] = 1'b0;
                    e_out[p] = pdrv[s];
                end else begin
                    e_out[p] = preset_of(s);
                end
            end
            lv = e_oe[p] ? ext[p] : e_out[p];
            if (!xp && !an) e_gin[p] = lv;
            if (!xp && pin_mode[p] == 2'd2 && s != 0) e_sen[s] = lv;
            if (an && p != PIN_PB2 && p != PIN_PB3) e_asw[p] = 1'b1;
        end
        e_ch0 = {pin_mode[PIN_PB3] == 2'd3, pin_mode[PIN_PB2] == 2'd3};
        e_cap = amp ? e_ch0 : 2'b00;
        e_ch0 = amp ? 2'b00 : e_ch0;
    endfunction

    // ------------------------------------------------------------
    // Checks and stimulus
    // ------------------------------------------------------------
    // Pad side after one edge, synchronised inputs after eight
    task automatic check_all(input bit full);
        predict();
        `CHK("pad_out", e_out, p_out)
        `CHK("pad_oe_n", e_oe, p_oe_n)
        `CHK("analog_switch", e_asw, asw)
        `CHK("channel0", e_ch0, ch0)
        `CHK("amp_cap", e_cap, cap)
        `CHK("crystal", {2{xen}}, xtal)
        if (full) begin
            `CHK("gpio_in", e_gin, g_in)
            `CHK("sense", e_sen, sen)
        end
    endtask

    task automatic settle();
        @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        check_all(1'b0);
        repeat (7) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        check_all(1'b1);
    endtask

    task automatic rand_cfg();
        logic [63:0] w, v;
        @(posedge clk_sys_in);
        w = {$random(seed), $random(seed)};
        v = {$random(seed), $random(seed)};
        pin_mode <= {$random(seed), $random(seed)};
        alt_idx <= {$random(seed), $random(seed), $random(seed)};
        gpo <= w[31:0];
        ext <= v[63:32];
        xen <= w[50];
        amp <= w[51];
        txb <= w[52];
        rxb <= w[53];
        pdrv <= {w[63:50], v[35:0]};
        // Software keeps USART traffic away from a running crystal
        // quiet USART
        if (w[50]) v[SIG_USART_TX:SIG_USART_RX] = 2'b00;
        pden <= v[NSIG-1:0];
    endtask

    // One pin in alternate mode, every other pin an input
    task automatic direct(input int k, input bit en);
        logic [63:0] w;
        logic [NPIN-1:0][1:0] m;
        logic [NPIN-1:0][AF_W-1:0] a;
        logic ex;
        @(posedge clk_sys_in);
        w = {$random(seed), $random(seed)};
        m = '0;
        a = '0;
        m[D_PIN[k]] = 2'd2;
        a[D_PIN[k]] = AF_W'(D_IDX[k]);
        pin_mode <= m;
        alt_idx <= a;
        xen <= 1'b0;
        txb <= w[60];
        rxb <= w[61];
        ext <= w[31:0];
        pdrv <= w[NSIG-1:0];
        pden <= {{(NSIG - 1){1'b0}}, en} << D_SIG[k];
        settle();
        ex = (D_SIG[k] == SIG_RADIO_TX_ACT) ? txb :
             (D_SIG[k] == SIG_RADIO_RX_ACT) ? rxb :
             en ? pdrv[D_SIG[k]] : preset_of(D_SIG[k]);
        `CHK("routed", ex, p_out[D_PIN[k]])
    endtask

    task automatic reset_check();
        // Quiet inputs during reset, so the first edges after release
        // agree with what the reset values of the outputs stand for
        pin_mode <= '0;
        alt_idx <= '0;
        gpo <= '0;
        xen <= 1'b0;
        amp <= 1'b0;
        txb <= 1'b0;
        rxb <= 1'b0;
        pdrv <= '0;
        pden <= '0;
        @(negedge clk_sys_in);
        `CHK("reset_oe_n", {NPIN{1'b1}}, p_oe_n)
        `CHK("reset_out", {NPIN{1'b0}}, p_out)
        `CHK("reset_sense", SENSE_IDLE, sen)
        @(posedge clk_sys_in);
        resetn_in <= 1'b1;
    endtask

    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys_in);
        reset_check();
        for (int k = 0; k < D_N; k++) begin
            for (int e = 0; e < 2; e++) begin
                direct(k, e[0]);
            end
        end
        repeat (80) begin
            rand_cfg();
            settle();
        end
        // Second reset in mid-run, then more random traffic
        @(posedge clk_sys_in);
        resetn_in <= 1'b0;
        reset_check();
        repeat (60) begin
            rand_cfg();
            settle();
        end
        close_out();
    end

    // Run needs about 1500 cycles; give it four times that
    initial begin
        #120000;
        n_errors++;
        close_out();
    end
endmodule
